// ### src/sc_charger_ctrl.sv
// Charger digital control: serial commands, safety, power path, converter sequencer
`timescale 1ns/1ps
module sc_charger_ctrl #(
	parameter logic [6:0]  SLAVE_ADDR = 7'h09,
	parameter int unsigned SAFETY_CYC = sc_pkg::SAFETY_S * sc_pkg::CLK_HZ
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// Serial bus pins
	input  wire logic        SMB_CLK_I,
	input  wire logic        SMB_DATA_I,
	output logic             SMB_DATA_O,
	output logic             SMB_DATA_OE_O,
	// Analog comparator inputs
	input  wire logic        ADAPTER_SENSE_I,
	input  wire logic        SUPPLY_DIFF_LOW_I,
	input  wire logic        TEMP_OPEN_I,
	input  wire logic        TEMP_COLD_I,
	input  wire logic        TEMP_HOT_I,
	input  wire logic        TEMP_SHORT_I,
	input  wire logic        LOW_CONTROL_CMP_I,
	input  wire logic        PEAK_CURRENT_CMP_I,
	input  wire logic        OVERCURRENT_CMP_I,
	input  wire logic        ZERO_CURRENT_CMP_I,
	// Power path and converter drives
	output logic             ADAPTER_OK_OUT_O,
	output logic             ADAPTER_OK_OUT_OE_O,
	output logic             SOURCE_SWITCH_DRIVE_O,
	output logic             LOAD_SWITCH_DRIVE_O,
	output logic             HIGH_SIDE_DRIVE_O,
	output logic             LOW_SIDE_DRIVE_O,
	// Setpoint and status
	output logic [10:0]      CHARGE_VOLTAGE_CODE_O,
	output logic             CHARGE_EN_O,
	output logic             VOLT_RANGE_ERR_O,
	output logic             TEMP_OPEN_FLAG_O,
	output logic             TEMP_COLD_FLAG_O,
	output logic             TEMP_HOT_FLAG_O,
	output logic             TEMP_SHORT_FLAG_O,
	output logic             PACK_PRESENT_O,
	output logic             ALARM_LOCKOUT_O,
	output logic             SAFETY_TIMEOUT_O
);

	// Parameter sanity
	if (SAFETY_CYC < 2 || SAFETY_CYC > 32'h7fffffff) begin : g_chk
		$error("SAFETY_CYC out of range");
	end
	localparam logic [30:0] TMR_END = 31'(SAFETY_CYC - 1); // Last count of the safety timer
	sc_pkg::sc_in_s    in_raw;     // Raw asynchronous inputs
	sc_pkg::sc_state_s s;          // Registered state
	sc_pkg::sc_state_s n;          // Next state
	logic              scl_rise;   // Serial clock edges
	logic              scl_fall;
	logic              wr;         // Completed word write, one cycle
	logic [15:0]       wdat;       // Word carried by that write
	logic              v_cmd;      // Decoded command strobes
	logic              i_cmd;
	logic              a_cmd;
	logic              c_cmd;
	logic              reinit;     // Soft return to power-on state
	logic              src_want;   // Adapter usable as supply
	logic              cyc_ok;     // New switching cycle allowed
	logic [10:0]       raw_vc;     // Unclamped voltage code

	// Gather pins so they cross the domain together
	assign in_raw = '{scl: SMB_CLK_I, sda: SMB_DATA_I, adapter: ADAPTER_SENSE_I,
		diff_low: SUPPLY_DIFF_LOW_I, t_open: TEMP_OPEN_I, t_cold: TEMP_COLD_I,
		t_hot: TEMP_HOT_I, t_short: TEMP_SHORT_I, low_ctrl: LOW_CONTROL_CMP_I,
		peak: PEAK_CURRENT_CMP_I, over_cur: OVERCURRENT_CMP_I, zero_cur: ZERO_CURRENT_CMP_I};

	// Next-state logic for the whole block
	always_comb begin
		n        = s;
		wr       = 1'b0;
		wdat     = 16'h0000;
		// Two-stage sampling; only the second stage is read below
		n.meta   = in_raw;
		n.sync   = s.meta;
		n.scl_d  = s.sync.scl;
		n.sda_d  = s.sync.sda;
		scl_rise = s.sync.scl & ~s.scl_d;
		scl_fall = ~s.sync.scl & s.scl_d;

		// Serial word-write receiver
		if (s.sync.scl && s.scl_d && s.sda_d && !s.sync.sda) begin
			// Start condition opens a new frame
			n.smb_act  = 1'b1;
			n.bit_cnt  = 4'h0;
			n.byte_idx = 2'h0;
			n.ack      = 1'b0;
		end else if (s.sync.scl && s.scl_d && !s.sda_d && s.sync.sda) begin
			// Stop condition
			n.smb_act = 1'b0;
			n.ack     = 1'b0;
		end else if (s.smb_act && scl_rise && s.bit_cnt < sc_pkg::BIT_ACK) begin
			// Data bit, most significant first
			n.shreg   = {s.shreg[6:0], s.sync.sda};
			n.bit_cnt = s.bit_cnt + 4'h1;
		end else if (s.smb_act && scl_fall && s.bit_cnt == sc_pkg::BIT_ACK) begin
			// Byte complete: decide acknowledge for the ninth clock
			n.bit_cnt = sc_pkg::BIT_END;
			case (s.byte_idx)
				2'h0: n.ack = (s.shreg[7:1] == SLAVE_ADDR) && !s.shreg[0];
				2'h1: begin
					n.cmd = s.shreg;
					n.ack = s.shreg inside {sc_pkg::CMD_CONFIG, sc_pkg::CMD_CURRENT,
						sc_pkg::CMD_VOLT, sc_pkg::CMD_ALARM};
				end
				2'h2: begin
					n.lo  = s.shreg;
					n.ack = 1'b1;
				end
				default: begin
					n.ack = 1'b1;
					wr    = 1'b1;
					wdat  = {s.shreg, s.lo};
				end
			endcase
			n.byte_idx = s.byte_idx + 2'h1;
		end else if (s.smb_act && scl_fall && s.bit_cnt == sc_pkg::BIT_END) begin
			// Release the line; a refused or final byte ends the frame
			n.ack     = 1'b0;
			n.bit_cnt = 4'h0;
			if (!s.ack || s.byte_idx == 2'h0) begin
				n.smb_act = 1'b0;
			end
		end

		// Command strobes
		v_cmd  = wr && s.cmd == sc_pkg::CMD_VOLT;
		i_cmd  = wr && s.cmd == sc_pkg::CMD_CURRENT;
		a_cmd  = wr && s.cmd == sc_pkg::CMD_ALARM;
		c_cmd  = wr && s.cmd == sc_pkg::CMD_CONFIG;
		reinit = c_cmd && wdat[sc_pkg::CFG_REINIT];
		raw_vc = wdat[sc_pkg::VC_MSB:sc_pkg::VC_LSB];

		// Open sensor or soft reinit returns to power-on values
		if (s.sync.t_open || reinit) begin
			n.vcode       = sc_pkg::VCODE_MIN;
			n.vrange      = 1'b0;
			n.hot_stop    = 1'b1;
			n.alarm_other = 1'b0;
			n.lockout     = 1'b0;
			n.got_v       = 1'b0;
			n.got_i       = 1'b0;
			n.hot         = 1'b0;
			n.tmr         = '0;
			n.timeout     = 1'b0;
		end

		// Configuration write
		if (c_cmd) begin
			n.hot_stop = wdat[sc_pkg::CFG_HOT_STP];
		end

		// Voltage setpoint: floor, ceiling, range flag
		if (v_cmd) begin
			if (raw_vc < sc_pkg::VCODE_MIN) begin
				n.vcode = sc_pkg::VCODE_MIN;
			end else if (raw_vc > sc_pkg::VCODE_MAX) begin
				n.vcode = sc_pkg::VCODE_MAX;
			end else begin
				n.vcode = raw_vc;
			end
			n.vrange = {1'b0, wdat[14:0]} > sc_pkg::VOLT_LIM;
			n.got_v  = 1'b1;
		end
		if (i_cmd) begin
			n.got_i = s.got_v;
		end
		// Voltage then current setpoint lifts the lockout
		if (i_cmd && s.got_v) begin
			n.lockout = 1'b0;
			n.got_v   = 1'b0;
			n.got_i   = 1'b0;
		end

		// Alarm command: only the top four bits matter
		if (a_cmd) begin
			n.alarm_other = wdat[sc_pkg::ALM_OTHER];
			if (wdat[sc_pkg::ALM_TEMP] || wdat[sc_pkg::ALM_TERM] || wdat[sc_pkg::ALM_OVCHG]) begin
				n.lockout = 1'b1;
				n.got_v   = 1'b0;
			end
		end

		// Safety timer; a setpoint command restarts it
		if (v_cmd || i_cmd) begin
			n.tmr     = '0;
			n.timeout = 1'b0;
		end else if (s.chg_en) begin
			if (s.tmr == TMR_END) begin
				n.tmr     = '0;
				n.timeout = 1'b1;
				n.lockout = 1'b1;
				n.got_v   = 1'b0;
			end else begin
				n.tmr = s.tmr + 31'h1;
			end
		end

		// Hot flag sets after clearing so a new trip is never lost
		if (s.sync.t_hot) begin
			n.hot = 1'b1;
		end

		// Power path: break-before-make when the source drops; load opens in the same cycle the source closes
		src_want = s.sync.adapter && !s.sync.diff_low;
		n.src_on = src_want;
		if (src_want) begin
			n.bbm     = '0;
			n.load_on = 1'b0;
		end else if (!s.load_on) begin
			if (s.bbm == sc_pkg::BBM_CYC) begin
				n.load_on = 1'b1;
			end else begin
				n.bbm = s.bbm + 7'h1;
			end
		end

		// Charge enable; cold flag deliberately absent
		n.chg_en = src_want && !s.sync.t_open && !n.lockout && !n.alarm_other &&
			!n.timeout && !(n.hot && n.hot_stop && !s.sync.t_short);

		// Converter sequencer
		cyc_ok = s.sync.low_ctrl && !s.sync.over_cur;
		case (s.conv)
			sc_pkg::CV_IDLE: begin
				n.hs = 1'b0;
				n.ls = 1'b0;
				if (s.chg_en && cyc_ok) begin
					n.conv = sc_pkg::CV_ON;
					n.hs   = 1'b1;
				end
			end
			sc_pkg::CV_ON: begin
				// Peak or overcurrent ends the on-time at once
				if (!s.chg_en || s.sync.peak || s.sync.over_cur) begin
					n.conv    = sc_pkg::CV_OFF;
					n.hs      = 1'b0;
					n.ls      = 1'b1;
					n.off_cnt = 2'h0;
				end
			end
			sc_pkg::CV_OFF: begin
				if (s.off_cnt != sc_pkg::OFF_END) begin
					n.off_cnt = s.off_cnt + 2'h1;
				end
				if (s.sync.zero_cur) begin
					n.ls = 1'b0;
				end
				if (!s.chg_en) begin
					n.conv = sc_pkg::CV_IDLE;
					n.ls   = 1'b0;
				end else if (s.off_cnt == sc_pkg::OFF_END && cyc_ok) begin
					n.conv = sc_pkg::CV_ON;
					n.hs   = 1'b1;
					n.ls   = 1'b0;
				end
			end
			default: begin
				n.conv = sc_pkg::CV_IDLE;
				n.hs   = 1'b0;
				n.ls   = 1'b0;
			end
		endcase
	end

	// State register, synchronous reset
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			s <= sc_pkg::ST_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from state
	assign SMB_DATA_O            = 1'b0;
	assign SMB_DATA_OE_O         = s.ack;
	assign ADAPTER_OK_OUT_O      = 1'b0;
	assign ADAPTER_OK_OUT_OE_O   = s.sync.adapter;
	assign SOURCE_SWITCH_DRIVE_O = s.src_on;
	assign LOAD_SWITCH_DRIVE_O   = s.load_on;
	assign HIGH_SIDE_DRIVE_O     = s.hs;
	assign LOW_SIDE_DRIVE_O      = s.ls;
	assign CHARGE_VOLTAGE_CODE_O = s.vcode;
	assign CHARGE_EN_O           = s.chg_en;
	assign VOLT_RANGE_ERR_O      = s.vrange;
	assign TEMP_OPEN_FLAG_O      = s.sync.t_open;
	assign TEMP_COLD_FLAG_O      = s.sync.t_cold;
	assign TEMP_HOT_FLAG_O       = s.hot;
	assign TEMP_SHORT_FLAG_O     = s.sync.t_short;
	assign PACK_PRESENT_O        = !s.sync.t_open;
	assign ALARM_LOCKOUT_O       = s.lockout;
	assign SAFETY_TIMEOUT_O      = s.timeout;

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	property p_vmin;
		v_cmd && wdat[14:10] == 5'h00 |=> s.vcode == sc_pkg::VCODE_MIN;
	endproperty
	a_vmin: assert property (p_vmin) else $error("voltage floor missed");
	property p_vmax;
		v_cmd |=> s.vcode <= sc_pkg::VCODE_MAX && s.vcode >= sc_pkg::VCODE_MIN;
	endproperty
	a_vmax: assert property (p_vmax) else $error("voltage ceiling missed");
	property p_vrange;
		v_cmd && !s.sync.t_open |=> s.vrange == ($past(wdat) > sc_pkg::VOLT_LIM && !$past(wdat[15])) ||
			($past(wdat[15]) && s.vrange == ({1'b0, $past(wdat[14:0])} > sc_pkg::VOLT_LIM));
	endproperty
	a_vrange: assert property (p_vrange) else $error("range flag wrong");
	property p_timeout;
		s.chg_en && s.tmr == TMR_END && !v_cmd && !i_cmd |=> s.timeout && !s.chg_en && s.lockout;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not stop charge");
	property p_alarm;
		a_cmd && wdat[15:12] != 4'h0 |=> !s.chg_en;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm did not stop charge");
	property p_hot;
		s.sync.t_hot |=> s.hot;
	endproperty
	a_hot: assert property (p_hot) else $error("hot flag not latched");
	property p_hot_stop;
		s.hot && s.hot_stop && !s.sync.t_short && !s.sync.t_open && !wr |=> !s.chg_en;
	endproperty
	a_hot_stop: assert property (p_hot_stop) else $error("hot did not stop charge");
	property p_iso;
		s.chg_en |-> !s.load_on && s.src_on;
	endproperty
	a_iso: assert property (p_iso) else $error("load switch on while charging");
	sequence s_bbm_wait;
		(!s.load_on) throughout (##74 1'b1);
	endsequence
	property p_bbm;
		$fell(s.src_on) |-> s_bbm_wait ##1 (s.load_on || s.src_on);
	endproperty
	a_bbm: assert property (p_bbm) else $error("break-before-make timing");
	property p_pdn;
		s.sync.diff_low |=> !s.src_on && !s.chg_en;
	endproperty
	a_pdn: assert property (p_pdn) else $error("power-down ignored");
	property p_off;
		$fell(s.hs) |-> !s.hs [*3];
	endproperty
	a_off: assert property (p_off) else $error("off-time too short");
	property p_start;
		$rose(s.hs) |-> $past(s.sync.low_ctrl) && !$past(s.sync.over_cur);
	endproperty
	a_start: assert property (p_start) else $error("cycle started while blocked");
	property p_oc;
		s.conv == sc_pkg::CV_ON && (s.sync.over_cur || s.sync.peak) |=> !s.hs;
	endproperty
	a_oc: assert property (p_oc) else $error("on-time not ended");
	// Both drives stay off unless the next cycle was allowed to begin at once
	property p_zc;
		s.conv == sc_pkg::CV_OFF && s.sync.zero_cur |=> !s.ls && (!s.hs || $past(cyc_ok));
	endproperty
	a_zc: assert property (p_zc) else $error("zero current left a drive on");

endmodule // sc_charger_ctrl

// ### src/sc_pkg.sv
// Constants, carrier types and state layout for the charger control logic
package sc_pkg;
	// Core clock
	localparam int unsigned CLK_NS     = 100;
	localparam int unsigned CLK_HZ     = 1_000_000_000 / CLK_NS;
	// Converter minimum off-time, rounded up
	localparam int unsigned OFF_MIN_NS = 300;
	localparam int unsigned OFF_CYC    = (OFF_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0]  OFF_END    = 2'(OFF_CYC - 1);
	// Break-before-make delay
	localparam int unsigned BBM_NS     = 7500;
	localparam logic [6:0]  BBM_CYC    = 7'(BBM_NS / CLK_NS);
	// Charge safety timeout in seconds
	localparam int unsigned SAFETY_S   = 175;
	// Command codes
	localparam logic [7:0]  CMD_CONFIG  = 8'h12;
	localparam logic [7:0]  CMD_CURRENT = 8'h14;
	localparam logic [7:0]  CMD_VOLT    = 8'h15;
	localparam logic [7:0]  CMD_ALARM   = 8'h16;
	// Voltage setpoint layout
	localparam int          VC_LSB      = 4;
	localparam int          VC_MSB      = 14;
	localparam logic [10:0] VCODE_MIN   = 11'h040;
	localparam logic [10:0] VCODE_MAX   = 11'h4b0;
	localparam logic [15:0] VOLT_LIM    = 16'h4b00;
	// Alarm bits
	localparam int          ALM_TEMP    = 12;
	localparam int          ALM_OTHER   = 13;
	localparam int          ALM_TERM    = 14;
	localparam int          ALM_OVCHG   = 15;
	// Configuration bits
	localparam int          CFG_REINIT  = 3;
	localparam int          CFG_HOT_STP = 10;
	// Serial bit counter marks
	localparam logic [3:0]  BIT_ACK     = 4'h8;
	localparam logic [3:0]  BIT_END     = 4'h9;

	// Pins sampled from outside the clock domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic adapter;
		logic diff_low;
		logic t_open;
		logic t_cold;
		logic t_hot;
		logic t_short;
		logic low_ctrl;
		logic peak;
		logic over_cur;
		logic zero_cur;
	} sc_in_s;

	// Converter sequencer states
	typedef enum logic [2:0] {
		CV_IDLE = 3'h1,
		CV_ON   = 3'h2,
		CV_OFF  = 3'h4
	} sc_conv_e;

	// Whole state of the control block
	typedef struct packed {
		sc_in_s      meta;
		sc_in_s      sync;
		logic        scl_d;
		logic        sda_d;
		logic        smb_act;
		logic [3:0]  bit_cnt;
		logic [1:0]  byte_idx;
		logic [7:0]  shreg;
		logic [7:0]  cmd;
		logic [7:0]  lo;
		logic        ack;
		logic [10:0] vcode;
		logic        vrange;
		logic        hot_stop;
		logic        alarm_other;
		logic        lockout;
		logic        got_v;
		logic        got_i;
		logic        hot;
		logic [30:0] tmr;
		logic        timeout;
		logic [6:0]  bbm;
		logic        src_on;
		logic        load_on;
		logic        chg_en;
		sc_conv_e    conv;
		logic [1:0]  off_cnt;
		logic        hs;
		logic        ls;
	} sc_state_s;

	localparam sc_state_s ST_RST = '{conv: CV_IDLE, hot_stop: 1'b1, vcode: VCODE_MIN, default: '0};
endpackage

// ### sim/sc_smb_host.sv
// Serial bus host model issuing write-word transfers
`timescale 1ns/1ps
module sc_smb_host (
	// Core clock
	input  wire logic clk_i,
	// Data wire level as resolved by the bench
	input  wire logic sda_i,
	// Bus drives
	output logic      scl_o,
	output logic      sda_pull_o
);
	int half = 4; // Cycles per bus clock phase; raise it for a slow host
	// Idle bus: clock stands high, data left to its pull-up
	initial begin
		scl_o      = 1'b1;
		sda_pull_o = 1'b0;
	end
	// One bit: data moves a cycle after the clock falls, so the device never sees it change while high
	task automatic put_bit(input logic b, output logic seen);
		scl_o <= 1'b0;
		@(posedge clk_i);
		sda_pull_o <= ~b;
		repeat (half - 1) @(posedge clk_i);
		scl_o <= 1'b1;
		repeat (half) @(posedge clk_i);
		seen = sda_i; // Sampled while the clock is still high
	endtask
	// Start, address, command, low byte, high byte, stop; gives up after a refusal
	task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] w, output int acks);
		logic [7:0] bytes [4];
		logic       seen;
		bytes = '{{addr, 1'b0}, cmd, w[7:0], w[15:8]};
		acks  = 0;
		@(posedge clk_i);
		sda_pull_o <= 1'b1; // Start: data falls while clock is high
		repeat (half) @(posedge clk_i);
		for (int i = 0; i < 4; i++) begin
			for (int j = 7; j >= 0; j--) begin
				put_bit(bytes[i][j], seen); // Most significant bit first
			end
			put_bit(1'b1, seen); // Released so the device can acknowledge
			if (seen !== 1'b0) begin
				break;
			end
			acks++;
		end
		scl_o <= 1'b0;
		@(posedge clk_i);
		sda_pull_o <= 1'b1;
		repeat (half - 1) @(posedge clk_i);
		scl_o <= 1'b1;
		repeat (half) @(posedge clk_i);
		sda_pull_o <= 1'b0; // Stop: data rises while clock is high
		repeat (half) @(posedge clk_i);
	endtask
endmodule // sc_smb_host

// ### sim/testbench.sv
// Self-checking bench for the charger control block
`timescale 1ns/1ps
module testbench;
	localparam int         SAFE  = 3000;  // Shortened safety timeout, core cycles
	localparam int         LIMIT = 40000; // Cycle ceiling for a hung run
	localparam logic [6:0] ADDR  = 7'h09; // Device bus address
	// Setpoint word beside the code and range flag it should give
	typedef struct packed {
		logic [15:0] word;
		logic [10:0] code;
		logic        range;
	} sc_row_s;
	sc_row_s rows [10] = '{
		'{16'h0000, 11'h040, 1'b0}, '{16'h03f0, 11'h040, 1'b0}, '{16'h0400, 11'h040, 1'b0},
		'{16'h4b00, 11'h4b0, 1'b0}, '{16'h4b01, 11'h4b0, 1'b1}, '{16'h4b10, 11'h4b0, 1'b1},
		'{16'h7fff, 11'h4b0, 1'b1}, '{16'hcb00, 11'h4b0, 1'b0}, '{16'h3ff5, 11'h3ff, 1'b0},
		'{16'h8410, 11'h041, 1'b0}};
	logic clk = 1'b0;   // Core clock
	logic rst_n = 1'b0; // Reset, active low
	// Comparator inputs; adapter present from the start
	logic adp = 1'b1, dif = 1'b0, t_op = 1'b0, t_cd = 1'b0, t_ht = 1'b0, t_sh = 1'b0;
	logic lowc = 1'b0, peak = 1'b0, ovc = 1'b0, zc = 1'b0;
	// Bus wires and observed outputs
	logic scl, pull, sda, sda_o, sda_oe, ok_o, ok_oe, src, load, hs, ls, en, vr, fop, fcd, fht, fsh, pack, lock, tmo;
	logic [10:0] code;
	logic [15:0] w;
	int mismatches = 0, total_checks = 0, cycles = 0, n, acks;
	// Data line has a pull-up; either side may pull it low
	assign sda = ~(pull | (sda_oe & ~sda_o));
	// 10 MHz core clock
	always #50 clk = ~clk;
	sc_smb_host host_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	sc_charger_ctrl #(.SLAVE_ADDR(ADDR), .SAFETY_CYC(SAFE)) dut_u (
		.CLK_I(clk), .RST_N_I(rst_n), .SMB_CLK_I(scl), .SMB_DATA_I(sda), .SMB_DATA_O(sda_o),
		.SMB_DATA_OE_O(sda_oe), .ADAPTER_SENSE_I(adp), .SUPPLY_DIFF_LOW_I(dif), .TEMP_OPEN_I(t_op),
		.TEMP_COLD_I(t_cd), .TEMP_HOT_I(t_ht), .TEMP_SHORT_I(t_sh), .LOW_CONTROL_CMP_I(lowc),
		.PEAK_CURRENT_CMP_I(peak), .OVERCURRENT_CMP_I(ovc), .ZERO_CURRENT_CMP_I(zc),
		.ADAPTER_OK_OUT_O(ok_o), .ADAPTER_OK_OUT_OE_O(ok_oe), .SOURCE_SWITCH_DRIVE_O(src),
		.LOAD_SWITCH_DRIVE_O(load), .HIGH_SIDE_DRIVE_O(hs), .LOW_SIDE_DRIVE_O(ls),
		.CHARGE_VOLTAGE_CODE_O(code), .CHARGE_EN_O(en), .VOLT_RANGE_ERR_O(vr), .TEMP_OPEN_FLAG_O(fop),
		.TEMP_COLD_FLAG_O(fcd), .TEMP_HOT_FLAG_O(fht), .TEMP_SHORT_FLAG_O(fsh), .PACK_PRESENT_O(pack),
		.ALARM_LOCKOUT_O(lock), .SAFETY_TIMEOUT_O(tmo));
	// Wait k edges, then sample at the falling edge where outputs are settled
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	// Compare and count; case inequality so unknowns never match
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	// Select a drive output by number
	function automatic logic pick(input int sel);
		case (sel)
			0: return src;
			1: return load;
			default: return hs;
		endcase
	endfunction
	// Bounded wait for a drive level, counting falling edges
	task automatic wait_level(input int sel, input logic lvl, output int k);
		k = 0;
		while (pick(sel) !== lvl && k < 200) begin
			@(negedge clk);
			k++;
		end
	endtask
	// Good write-word frame, all four bytes acknowledged
	task automatic send(input logic [7:0] cmd, input logic [15:0] word);
		host_u.write_word(ADDR, cmd, word, acks);
		check(acks, 4, "acknowledge count");
		settle(2);
	endtask
	// Counts and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		check(code, 11'h040, "reset code");
		check({sda_o, sda_oe, ok_o, ok_oe, src, load, hs, ls, en, vr, fop, fcd, fht, fsh, pack, lock, tmo}, 17'h00004, "reset");
		@(posedge clk);
		rst_n <= 1'b1;
		settle(6);
		check({ok_oe, src, load, en, pack}, 5'b11011, "adapter present");
		$display("test reset done");
		foreach (rows[k]) begin
			send(sc_pkg::CMD_VOLT, rows[k].word);
			check(code, rows[k].code, "setpoint code");
			check(vr, rows[k].range, "range flag");
		end
		$display("test setpoint table done");
		host_u.half = 6; // Slow host for these frames
		host_u.write_word(7'h0a, sc_pkg::CMD_VOLT, 16'h1000, acks);
		check(acks, 0, "foreign address");
		host_u.write_word(ADDR, 8'h13, 16'h1000, acks);
		check(acks, 1, "unknown command");
		check(code, 11'h041, "code kept");
		send(sc_pkg::CMD_VOLT, 16'h1000);
		check(code, 11'h100, "slow frame code");
		host_u.half = 4;
		$display("test refusals done");
		for (int i = 0; i < 5; i++) begin
			w = (i < 4) ? (16'h1000 << i) : 16'h0fff;
			send(sc_pkg::CMD_ALARM, w);
			check(en, i == 4, "alarm charging");
			check(lock, i != 1 && i != 4, "alarm lockout");
			send(sc_pkg::CMD_ALARM, 16'h0000);
			send(sc_pkg::CMD_VOLT, 16'h2000);
			send(sc_pkg::CMD_CURRENT, 16'h0100);
			check({lock, en}, 2'b01, "lockout cleared");
		end
		$display("test alarms done");
		@(posedge clk);
		t_cd <= 1'b1;
		settle(6);
		check({fcd, en}, 2'b11, "cold charges");
		@(posedge clk);
		t_ht <= 1'b1;
		settle(6);
		check({fht, en}, 2'b10, "hot stops");
		@(posedge clk);
		t_ht <= 1'b0;
		t_sh <= 1'b1;
		settle(6);
		check({fht, fsh, en}, 3'b111, "hot with short");
		@(posedge clk);
		t_sh <= 1'b0;
		settle(6);
		check({fht, en}, 2'b10, "hot latched");
		send(sc_pkg::CMD_CONFIG, 16'h0000);
		check({fht, en}, 2'b11, "hot stop off");
		send(sc_pkg::CMD_CONFIG, 16'h0408);
		check({fht, en}, 2'b01, "reinit");
		@(posedge clk);
		t_ht <= 1'b1;
		settle(6);
		@(posedge clk);
		t_ht <= 1'b0;
		t_op <= 1'b1;
		settle(6);
		check({fop, pack, fht, en, code}, {4'b1000, 11'h040}, "open sensor");
		@(posedge clk);
		t_op <= 1'b0;
		t_cd <= 1'b0;
		settle(6);
		check({fcd, pack, en}, 3'b011, "pack back");
		$display("test temperature done");
		send(sc_pkg::CMD_CURRENT, 16'h0100);
		settle(20);
		check(hs, 0, "no start while low");
		@(posedge clk);
		lowc <= 1'b1;
		@(negedge clk);
		wait_level(2, 1'b1, n);
		check(n < 8, 1, "cycle start");
		@(posedge clk);
		peak <= 1'b1;
		repeat (2) @(posedge clk);
		peak <= 1'b0;
		@(negedge clk);
		wait_level(2, 1'b0, n);
		check(ls, 1, "peak ends on-time");
		wait_level(2, 1'b1, n);
		check(n >= sc_pkg::OFF_CYC, 1, "off-time");
		@(posedge clk);
		lowc <= 1'b0;
		peak <= 1'b1;
		zc <= 1'b1;
		settle(8);
		check({hs, ls}, 2'b00, "zero current");
		@(posedge clk);
		peak <= 1'b0;
		zc <= 1'b0;
		ovc <= 1'b1;
		lowc <= 1'b1;
		settle(20);
		check(hs, 0, "overcurrent blocks");
		@(posedge clk);
		ovc <= 1'b0;
		@(negedge clk);
		wait_level(2, 1'b1, n);
		check(n < 8, 1, "restart");
		@(posedge clk);
		ovc <= 1'b1;
		@(negedge clk);
		wait_level(2, 1'b0, n);
		check(n < 5, 1, "overcurrent ends on-time");
		@(posedge clk);
		ovc <= 1'b0;
		lowc <= 1'b0;
		$display("test converter done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			adp <= (i == 1);
			dif <= (i == 1);
			@(negedge clk);
			wait_level(0, 1'b0, n);
			check(load, 0, "break first");
			wait_level(1, 1'b1, n);
			check({n[6:0], ok_oe, en}, {sc_pkg::BBM_CYC, 1'(i), 1'b0}, "make delay");
			@(posedge clk);
			adp <= 1'b1;
			dif <= 1'b0;
			@(negedge clk);
			wait_level(0, 1'b1, n);
			check({load, ok_oe}, 2'b01, "source back");
		end
		$display("test power path done");
		send(sc_pkg::CMD_CURRENT, 16'h0100);
		settle(SAFE - 1000);
		send(sc_pkg::CMD_CURRENT, 16'h0100);
		settle(SAFE - 500);
		check({tmo, en}, 2'b01, "timer restarted");
		settle(700);
		check({tmo, en, lock}, 3'b101, "safety timeout");
		send(sc_pkg::CMD_VOLT, 16'h2000);
		send(sc_pkg::CMD_CURRENT, 16'h0100);
		check({tmo, en, lock}, 3'b010, "charging again");
		$display("test timeout done");
		conclude();
	end
endmodule // testbench
